// ---- framer_model.sv ----
`timescale 1ns/1ps
module framer_model (
    // Frame control from the bench
    input  wire logic       go,
    input  wire logic       riseSample,
    input  wire logic [7:0] posBits,
    input  wire logic [7:0] negBits,
    // Link pins
    output logic            busy,
    output logic            tx_line_clock,
    output logic            tx_pos_rail,
    output logic            tx_neg_rail
);
    initial begin
        busy = 1'b0;
        tx_line_clock = 1'b0;
        tx_pos_rail = 1'b0;
        tx_neg_rail = 1'b1;
    end

    // The clock stands low between frames; the odd offset keeps it out of
    // phase with the system clock. Data moves on the edge that is not
    // sampled, so it holds half a period around each sample.
    always @(posedge go) begin
        busy = 1'b1;
        #7;
        for (int i = 0; i < 8; i++) begin
            if (!riseSample)
                tx_line_clock = 1'b1;
            tx_pos_rail = posBits[i];
            tx_neg_rail = negBits[i];
            #160 tx_line_clock = ~tx_line_clock;
            #160 tx_line_clock = 1'b0;
        end
        // Released rails must not look like held data.
        tx_pos_rail = ~tx_pos_rail;
        tx_neg_rail = ~tx_neg_rail;
        busy = 1'b0;
    end
endmodule // framer_model

// ---- liu_line_data_port.sv ----
`timescale 1ns/1ps
module liu_line_data_port #(
    parameter int TX_LOSS_CYCLES = liu_line_data_port_pkg::TX_LOSS_CYC
) (
    // Clock and reset
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_b,
    // AHB-Lite register slave
    input  wire logic                                    hsel,
    input  wire logic [liu_line_data_port_pkg::DATA_W-1:0] haddr,
    input  wire logic [1:0]                              htrans,
    input  wire logic                                    hwrite,
    input  wire logic [2:0]                              hsize,
    input  wire logic [liu_line_data_port_pkg::DATA_W-1:0] hwdata,
    input  wire logic                                    hready,
    output logic                                         hreadyout,
    output logic                                         hresp,
    output logic [liu_line_data_port_pkg::DATA_W-1:0]    hrdata,
    output logic                                         irq,
    // Recovery front end and device pins
    input  wire logic                                    rxRecClk,
    input  wire logic                                    rxRecPos,
    input  wire logic                                    rxRecNeg,
    input  wire logic                                    rxRecErr,
    input  wire logic                                    carrierLoss,
    input  wire logic                                    masterClk,
    input  wire logic                                    hwMode,
    input  wire logic                                    testMode,
    input  wire logic                                    hard_reset_n,
    // Receive side outputs
    output logic                                         rxClkOut,
    output logic                                         rxClkOutOe,
    output logic                                         rx_pos_rail,
    output logic                                         rxPosOe,
    output logic                                         rx_neg_rail,
    output logic                                         rxNegOe,
    output logic                                         loss_indicator_out,
    output logic                                         lossOe,
    // Transmit side
    input  wire logic                                    tx_line_clock,
    input  wire logic                                    tx_pos_rail,
    input  wire logic                                    tx_neg_rail,
    output logic                                         txPosData,
    output logic                                         txNegData,
    output logic                                         txStrobe
);
    import liu_line_data_port_pkg::*;

    typedef struct packed {
        logic [CTRL_W-1:0] ctrl;
        logic [EV_W-1:0]   mask;
        logic [EV_W-1:0]   status;
        logic [DATA_W-1:0] rdata;
        logic              wrPend;
        logic [ADDR_W-1:0] wrAddr;
        logic              rxClk;
        logic              txClk;
        logic              txPinPrev;
        logic [CNT_W-1:0]  lossCnt;
        logic              txLoss;
        logic              carrierPrev;
        logic              lossOut;
        logic              rxPos;
        logic              rxNeg;
        logic              txPos;
        logic              txNeg;
        logic              txStrobe;
    } port_s;

    port_s st;
    port_s next_st;

    logic [IN_W-1:0] pins;
    logic [IN_W-1:0] syn;
    logic            selRx;
    logic            rxUpd;
    logic            txSel;
    logic            txSmp;
    logic            pinEdge;
    logic            effSel;
    logic            busAcc;
    logic [EV_W-1:0] evSet;
    logic [EV_W-1:0] evClr;

    initial begin
        if (TX_LOSS_CYCLES < 1 || TX_LOSS_CYCLES >= (1 << CNT_W)) begin
            $error("TX_LOSS_CYCLES must lie between 1 and 255");
        end
    end

    function automatic logic [DATA_W-1:0] read_reg(
        input logic [ADDR_W-1:0] addr,
        input port_s             s,
        input logic [IN_W-1:0]   y
    );
        logic [DATA_W-1:0] r;
        r = '0;
        case (addr)
            OFF_CTRL:   r[CTRL_W-1:0] = s.ctrl;
            OFF_STATUS: r[EV_W-1:0] = s.status;
            OFF_MASK:   r[EV_W-1:0] = s.mask;
            OFF_STATE: begin
                r[ST_CARRIER] = y[IN_CARRIER];
                r[ST_TXLOSS]  = s.txLoss;
                r[ST_HWMODE]  = y[IN_HWMODE];
                r[ST_TEST]    = y[IN_TEST];
            end
            default:    r = '0;
        endcase
        return r;
    endfunction

    // Every input here comes from outside ref_clk, so all pass two stages.
    assign pins = {tx_neg_rail, tx_pos_rail, hard_reset_n, testMode, hwMode,
                   carrierLoss, rxRecErr, rxRecNeg, rxRecPos, tx_line_clock,
                   masterClk, rxRecClk};

    pin_sync #(
        .WIDTH (IN_W)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .asyncIn (pins),
        .syncOut (syn)
    );

    always_comb begin
        next_st = st;

        // With no line signal the output clock follows the master clock.
        selRx = syn[IN_CARRIER] ? syn[IN_MCLK] : syn[IN_RECCLK];
        next_st.rxClk = selRx;
        rxUpd = st.ctrl[CTRL_RX_EDGE] ? (st.rxClk & ~selRx)
                                      : (~st.rxClk & selRx);
        if (rxUpd) begin
            if (st.ctrl[CTRL_NRZ]) begin
                next_st.rxPos = syn[IN_RXPOS] | syn[IN_RXNEG];
                next_st.rxNeg = syn[IN_RXERR];
            end else begin
                next_st.rxPos = syn[IN_RXPOS];
                next_st.rxNeg = syn[IN_RXNEG];
            end
        end

        case (st.ctrl[CTRL_TXSRC_LO +: 2])
            TXSRC_PIN:    txSel = syn[IN_TXPIN];
            TXSRC_MASTER: txSel = syn[IN_MCLK];
            TXSRC_RECOV:  txSel = st.rxClk;
            default:      txSel = syn[IN_TXPIN];
        endcase
        next_st.txClk = txSel;
        txSmp = st.ctrl[CTRL_TX_EDGE] ? (~st.txClk & txSel)
                                      : (st.txClk & ~txSel);
        next_st.txStrobe = txSmp;
        if (txSmp) begin
            next_st.txPos = syn[IN_TXPOS];
            next_st.txNeg = syn[IN_TXNEG];
        end

        // The loss watch always looks at the pin, whatever clock is chosen.
        next_st.txPinPrev = syn[IN_TXPIN];
        pinEdge = syn[IN_TXPIN] ^ st.txPinPrev;
        if (pinEdge) begin
            next_st.lossCnt = '0;
        end else if (st.lossCnt < CNT_W'(TX_LOSS_CYCLES)) begin
            next_st.lossCnt = st.lossCnt + CNT_W'(1);
        end
        next_st.txLoss = !pinEdge
                         && (st.lossCnt >= CNT_W'(TX_LOSS_CYCLES));

        effSel = st.ctrl[CTRL_LOSS_SRC] & ~syn[IN_HWMODE];
        next_st.lossOut = effSel ? st.txLoss : syn[IN_CARRIER];

        next_st.carrierPrev = syn[IN_CARRIER];
        evSet = '0;
        evSet[EV_CARRIER] = syn[IN_CARRIER] & ~st.carrierPrev;
        evSet[EV_TXLOSS]  = next_st.txLoss & ~st.txLoss;
        evSet[EV_RXERR]   = rxUpd & st.ctrl[CTRL_NRZ] & syn[IN_RXERR];

        // Bus: address phase captured here, write data used one cycle on.
        busAcc = hsel & htrans[HTRANS_ACT_BIT] & hready;
        evClr = '0;
        next_st.wrPend = busAcc & hwrite;
        next_st.wrAddr = haddr[ADDR_W-1:0];
        if (busAcc && !hwrite) begin
            next_st.rdata = read_reg(haddr[ADDR_W-1:0], st, syn);
            if (haddr[ADDR_W-1:0] == OFF_STATUS) begin
                evClr = st.status;
            end
        end
        if (st.wrPend) begin
            case (st.wrAddr)
                OFF_CTRL: next_st.ctrl = hwdata[CTRL_W-1:0];
                OFF_MASK: next_st.mask = hwdata[EV_W-1:0];
                default:  next_st.mask = st.mask;
            endcase
        end
        // A new event in the clearing cycle survives the clear.
        next_st.status = (st.status & ~evClr) | evSet;

        if (!syn[IN_HARD_RESET_N]) begin
            next_st.ctrl = CTRL_RESET;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st      <= '0;
            st.ctrl <= CTRL_RESET;
            st.mask <= EV_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;
    assign irq       = |(st.status & st.mask);

    assign rxClkOut           = st.rxClk;
    assign rx_pos_rail        = st.rxPos;
    assign rx_neg_rail        = st.rxNeg;
    assign loss_indicator_out = st.lossOut;
    assign rxClkOutOe = ~syn[IN_TEST];
    assign rxPosOe    = ~syn[IN_TEST];
    assign rxNegOe    = ~syn[IN_TEST];
    assign lossOe     = ~syn[IN_TEST];
    assign txPosData  = st.txPos;
    assign txNegData  = st.txNeg;
    assign txStrobe   = st.txStrobe;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_rx_clock_master: assert property (
        syn[IN_CARRIER] |=> rxClkOut == $past(syn[IN_MCLK]))
        else $error("recovered clock output lost the master clock");

    a_carrier_loss_out: assert property (
        (!effSel && syn[IN_CARRIER]) |=> loss_indicator_out)
        else $error("loss output low during carrier loss");

    a_tx_loss_out: assert property (
        (effSel && st.txLoss) |=> loss_indicator_out)
        else $error("loss output low after transmit clock stopped");

    a_tx_loss_clear: assert property (
        pinEdge |=> !st.txLoss ##1 (!effSel || !loss_indicator_out))
        else $error("transmit clock loss kept after a pin edge");

    a_hw_mode_loss: assert property (
        (syn[IN_HWMODE] && syn[IN_CARRIER]) |=> loss_indicator_out)
        else $error("hardware mode did not report carrier loss");

    a_rail_edge: assert property (
        (!$stable(rx_pos_rail) || !$stable(rx_neg_rail)) |-> $past(rxUpd))
        else $error("receive rail changed away from the chosen edge");

    a_nrz_data: assert property (
        (rxUpd && st.ctrl[CTRL_NRZ])
        |=> rx_pos_rail == ($past(syn[IN_RXPOS]) | $past(syn[IN_RXNEG])))
        else $error("NRZ data wrong on positive rail");

    a_nrz_error: assert property (
        (rxUpd && st.ctrl[CTRL_NRZ] && syn[IN_RXERR]) |=> rx_neg_rail)
        else $error("line error gave no pulse on negative rail");

    a_tx_sample: assert property (
        txSmp |=> txStrobe && txPosData == $past(syn[IN_TXPOS])
                  && txNegData == $past(syn[IN_TXNEG]))
        else $error("transmit rails not sampled on the chosen edge");

    a_test_float: assert property (
        syn[IN_TEST] |-> !(rxClkOutOe || rxPosOe || rxNegOe || lossOe))
        else $error("an output drove while test was high");

    a_hard_reset: assert property (
        !syn[IN_HARD_RESET_N] |=> st.ctrl == CTRL_RESET)
        else $error("hardware reset left a control bit set");

    a_status_sticky: assert property (
        (st.status[EV_RXERR] && !(busAcc && !hwrite)) |=> st.status[EV_RXERR])
        else $error("status bit dropped without a read");
endmodule // liu_line_data_port

// ---- liu_line_data_port_pkg.sv ----
// What this block does
// - Recovered clock output keeps running from master clock when carrier is lost.
// - Loss source select 0: loss output high while carrier loss lasts.
// - Loss source select 1: loss output high after 5us without transmit clock edge.
// - Hardware mode forces the loss source select to 0.
// - Receive rails update on rising recovered edge, or falling when select is 1.
// - NRZ enable puts received data as one NRZ stream on positive rail.
// - In NRZ mode each line error pulses the negative rail high.
// - Transmit rails sampled on falling edge, or rising when select is 1.
// - Test input high floats the receive clock, both receive rails and the loss output; low means normal operation.
// - Hardware reset low returns every control bit to zero.
package liu_line_data_port_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFF_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_STATE  = 8'h0C;

    // Control register fields.
    localparam int CTRL_W        = 6;
    localparam int CTRL_RX_EDGE  = 0;
    localparam int CTRL_TX_EDGE  = 1;
    localparam int CTRL_NRZ      = 2;
    localparam int CTRL_LOSS_SRC = 3;
    localparam int CTRL_TXSRC_LO = 4;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h00;

    // Transmit clock source codes.
    localparam logic [1:0] TXSRC_PIN    = 2'h0;
    localparam logic [1:0] TXSRC_MASTER = 2'h1;
    localparam logic [1:0] TXSRC_RECOV  = 2'h2;

    // Event bits, shared by status and mask.
    localparam int EV_W       = 3;
    localparam int EV_CARRIER = 0;
    localparam int EV_TXLOSS  = 1;
    localparam int EV_RXERR   = 2;
    localparam logic [EV_W-1:0] EV_RESET = 3'h0;

    // Live state register fields.
    localparam int ST_CARRIER = 0;
    localparam int ST_TXLOSS  = 1;
    localparam int ST_HWMODE  = 2;
    localparam int ST_TEST    = 3;

    // Positions of the asynchronous inputs in the synchroniser vector.
    localparam int IN_RECCLK  = 0;
    localparam int IN_MCLK    = 1;
    localparam int IN_TXPIN   = 2;
    localparam int IN_RXPOS   = 3;
    localparam int IN_RXNEG   = 4;
    localparam int IN_RXERR   = 5;
    localparam int IN_CARRIER = 6;
    localparam int IN_HWMODE  = 7;
    localparam int IN_TEST    = 8;
    localparam int IN_HARD_RESET_N    = 9;
    localparam int IN_TXPOS   = 10;
    localparam int IN_TXNEG   = 11;
    localparam int IN_W       = 12;

    localparam int HTRANS_ACT_BIT = 1;

    // Timing.
    localparam int CLK_PERIOD_NS = 40;
    localparam int TX_LOSS_NS    = 5000;
    localparam int TX_LOSS_CYC   = TX_LOSS_NS / CLK_PERIOD_NS;
    localparam int CNT_W         = 8;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    // Signals
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } sync_s;

    sync_s st;
    sync_s next_st;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync needs WIDTH of at least one");
        end
    end

    // The first stage feeds only the second one, never any logic.
    always_comb begin
        next_st        = st;
        next_st.first  = asyncIn;
        next_st.second = st.first;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.second;
endmodule // pin_sync

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import liu_line_data_port_pkg::*;
    localparam int TXL = 8;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        hsel, hwrite, hreadyout, irq;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata;
    logic        rxRecClk, rxRecPos, rxRecNeg, rxRecErr, carrierLoss;
    logic        masterClk, hwMode, testMode, hard_reset_n, rxClkOut;
    logic        rx_pos_rail, rx_neg_rail, loss_indicator_out;
    logic [3:0]  oe;
    logic        tx_line_clock, tx_pos_rail, tx_neg_rail;
    logic        txPosData, txNegData, txStrobe, go, riseSample, busy;
    logic [7:0]  posBits, negBits;
    logic        qp[$], qn[$];
    int          mismatches = 0, total_checks = 0, cycles = 0;

    always #20 ref_clk = ~ref_clk;

    liu_line_data_port #(.TX_LOSS_CYCLES(TXL)) dut_u (
        .ref_clk(ref_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(),
        .hrdata(hrdata), .irq(irq), .rxRecClk(rxRecClk),
        .rxRecPos(rxRecPos), .rxRecNeg(rxRecNeg), .rxRecErr(rxRecErr),
        .carrierLoss(carrierLoss), .masterClk(masterClk), .hwMode(hwMode),
        .testMode(testMode), .hard_reset_n(hard_reset_n),
        .rxClkOut(rxClkOut), .rxClkOutOe(oe[3]), .rx_pos_rail(rx_pos_rail),
        .rxPosOe(oe[2]), .rx_neg_rail(rx_neg_rail), .rxNegOe(oe[1]),
        .loss_indicator_out(loss_indicator_out), .lossOe(oe[0]),
        .tx_line_clock(tx_line_clock), .tx_pos_rail(tx_pos_rail),
        .tx_neg_rail(tx_neg_rail), .txPosData(txPosData),
        .txNegData(txNegData), .txStrobe(txStrobe)
    );

    framer_model far_u (
        .go(go), .riseSample(riseSample), .posBits(posBits),
        .negBits(negBits), .busy(busy), .tx_line_clock(tx_line_clock),
        .tx_pos_rail(tx_pos_rail), .tx_neg_rail(tx_neg_rail)
    );

    // The strobe is a one-cycle register pulse, so sampling it mid-cycle
    // avoids racing the edge that launches it.
    always @(negedge ref_clk) begin
        if (txStrobe === 1'b1) begin
            qp.push_back(txPosData);
            qn.push_back(txNegData);
        end
    end

    task automatic summarize();
        if (mismatches == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string nm, input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        logic r;
        @(posedge ref_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, a};
        do begin
            @(negedge ref_clk);
            r = hreadyout;
            @(posedge ref_clk);
        end while (r !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do begin
            @(negedge ref_clk);
            r = hreadyout;
            rd = hrdata;
            @(posedge ref_clk);
        end while (r !== 1'b1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] m, exp);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, x & m, exp);
    endtask

    // Pins: 0 recovered clock, 1 master clock, 2 carrier loss,
    // 3 hardware mode, 4 test, 5 hardware reset.
    task automatic pin(input int k, input logic v);
        @(posedge ref_clk);
        case (k)
            0: rxRecClk <= v;
            1: masterClk <= v;
            2: carrierLoss <= v;
            3: hwMode <= v;
            4: testMode <= v;
            default: hard_reset_n <= v;
        endcase
        cyc(6);
    endtask

    task automatic rxd(input logic p, n, e);
        @(posedge ref_clk);
        rxRecPos <= p;
        rxRecNeg <= n;
        rxRecErr <= e;
        cyc(4);
    endtask

    task automatic frame(input logic r, input logic [7:0] p, n);
        @(posedge ref_clk);
        riseSample <= r;
        posBits <= p;
        negBits <= n;
        go <= 1'b1;
        @(posedge ref_clk);
        go <= 1'b0;
        cyc(2);
    endtask

    task automatic t_regs();
        rdc("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        rdc("mask", OFF_MASK, 32'hFFFFFFFF, 32'h0);
        rdc("unmapped", 8'h10, 32'hFFFFFFFF, 32'h0);
        wr(OFF_CTRL, 32'h0000000F);
        rdc("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h0000000F);
        pin(5, 1'b0);
        rdc("ctrl", OFF_CTRL, 32'hFFFFFFFF, 32'h0);
        pin(5, 1'b1);
    endtask

    task automatic t_rx();
        wr(OFF_CTRL, 32'h0);
        rxd(1'b1, 1'b0, 1'b0);
        pin(0, 1'b1);
        chk("rxpos", rx_pos_rail, 32'h1);
        chk("rxneg", rx_neg_rail, 32'h0);
        rxd(1'b0, 1'b1, 1'b0);
        pin(0, 1'b0);
        chk("rxpos", rx_pos_rail, 32'h1);
        wr(OFF_CTRL, 32'h1);
        pin(0, 1'b1);
        chk("rxpos", rx_pos_rail, 32'h1);
        pin(0, 1'b0);
        chk("rxpos", rx_pos_rail, 32'h0);
        chk("rxneg", rx_neg_rail, 32'h1);
    endtask

    task automatic t_nrz();
        wr(OFF_CTRL, 32'h4);
        rdc("status", OFF_STATUS, 32'h4, 32'h0);
        rxd(1'b0, 1'b1, 1'b1);
        pin(0, 1'b1);
        chk("nrzdata", rx_pos_rail, 32'h1);
        chk("nrzerr", rx_neg_rail, 32'h1);
        // A negative mark with no error must not reach the negative rail.
        rxd(1'b0, 1'b1, 1'b0);
        pin(0, 1'b0);
        pin(0, 1'b1);
        chk("nrzdata", rx_pos_rail, 32'h1);
        chk("nrzerr", rx_neg_rail, 32'h0);
        rdc("status", OFF_STATUS, 32'h4, 32'h4);
        pin(0, 1'b0);
    endtask

    task automatic t_loss();
        wr(OFF_CTRL, 32'h0);
        pin(2, 1'b1);
        chk("loss", loss_indicator_out, 32'h1);
        pin(1, 1'b1);
        chk("rxclk", rxClkOut, 32'h1);
        pin(1, 1'b0);
        chk("rxclk", rxClkOut, 32'h0);
        pin(3, 1'b1);
        wr(OFF_CTRL, 32'h8);
        cyc(4);
        chk("loss", loss_indicator_out, 32'h1);
        pin(2, 1'b0);
        chk("loss", loss_indicator_out, 32'h0);
        pin(3, 1'b0);
        chk("loss", loss_indicator_out, 32'h1);
        frame(1'b0, 8'h00, 8'h00);
        cyc(30);
        chk("loss", loss_indicator_out, 32'h0);
        while (busy === 1'b1)
            cyc(1);
        chk("loss", loss_indicator_out, 32'h0);
        cyc(TXL + 6);
        chk("loss", loss_indicator_out, 32'h1);
        wr(OFF_CTRL, 32'h0);
    endtask

    task automatic t_tx(input logic r, input logic [7:0] p, n);
        wr(OFF_CTRL, {30'h0, r, 1'b0});
        qp.delete();
        qn.delete();
        frame(r, p, n);
        while (busy === 1'b1)
            cyc(1);
        cyc(6);
        chk("txcount", qp.size(), 32'h8);
        for (int i = 0; i < 8; i++) begin
            chk("txpos", qp[i], p[i]);
            chk("txneg", qn[i], n[i]);
        end
    endtask

    task automatic t_src();
        wr(OFF_CTRL, 32'h10);
        qp.delete();
        repeat (3) begin
            pin(1, 1'b1);
            pin(1, 1'b0);
        end
        chk("strobes", qp.size(), 32'h3);
        // The recovered clock can drive the transmit side as well.
        wr(OFF_CTRL, 32'h20);
        qp.delete();
        repeat (3) begin
            pin(0, 1'b1);
            pin(0, 1'b0);
        end
        chk("strobes", qp.size(), 32'h3);
        wr(OFF_CTRL, 32'h0);
    endtask

    task automatic t_test();
        pin(4, 1'b1);
        chk("oe", {28'h0, oe}, 32'h0);
        pin(4, 1'b0);
        chk("oe", {28'h0, oe}, 32'hF);
    endtask

    task automatic t_irq();
        wr(OFF_MASK, 32'h0);
        rdc("status", OFF_STATUS, 32'h1, 32'h1);
        rdc("status", OFF_STATUS, 32'h1, 32'h0);
        pin(2, 1'b1);
        chk("irq", irq, 32'h0);
        wr(OFF_MASK, 32'h1);
        cyc(2);
        chk("irq", irq, 32'h1);
        rdc("status", OFF_STATUS, 32'h1, 32'h1);
        cyc(2);
        chk("irq", irq, 32'h0);
        pin(2, 1'b0);
    endtask

    initial begin
        {hsel, hwrite, htrans, haddr, hwdata, rxRecClk, rxRecPos} = '0;
        {rxRecNeg, rxRecErr, carrierLoss, masterClk, hwMode} = '0;
        {testMode, go, riseSample, posBits, negBits} = '0;
        hard_reset_n = 1'b1;
        repeat (8) @(posedge ref_clk);
        rst_b <= 1'b1;
        // Control writes right after reset may be lost in the sync stages.
        repeat (4) @(posedge ref_clk);
        t_regs();
        t_rx();
        t_nrz();
        t_loss();
        t_tx(1'b0, 8'hB4, 8'h4B);
        t_tx(1'b1, 8'h36, 8'hC9);
        t_src();
        t_test();
        t_irq();
        summarize();
    end
endmodule // tb_top
